// >>> design/low_power_mode_controller.sv
// Operation
// - standby instruction in active mode enters standby
// - standby keeps oscillator, stops instruction clock, halts cpu
// - standby keeps interrupts, timers and serial running
// - standby keeps port output levels and peripheral outputs
// - standby left on reset or any interrupt request
// - interrupt wake returns to active, continues next instruction
// - stop instruction in active mode enters stop, oscillator halts
// - stop holds peripherals in reset, outputs high impedance
// - stop exit resumes active fetching from address zero
// - ram valid cleared on reset exit, set on cancel exit
// - stop cancel acted on only in stop; reset cancels all
// - cpu working registers may be undefined after stop
// - reset acts asynchronously from any mode
// - pending unmasked request with interrupts off makes sleep a nop
// - after reset or stop exit divider follows strap pin
// - request exists when flag is one and mask is zero
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "lpm_defines.svh"
module low_power_mode_controller
   import lpm_pkg::*;
#(
   parameter int NUM_SRC = 6
) (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // cpu core
   input  wire logic               standby_instr,
   input  wire logic               stop_instr,
   input  wire logic               global_int_enable,
   output logic                    instr_nop,
   output logic                    cpu_clk_en,
   output logic                    fetch_from_zero,
   // interrupt controller
   input  wire logic [NUM_SRC-1:0] int_req_flag,
   input  wire logic [NUM_SRC-1:0] int_mask_bit,
   // pins
   input  wire logic               stop_cancel_n,
   input  wire logic               div_sel,
   // clock and reset control
   output logic                    osc_enable,
   output logic                    periph_clk_en,
   output logic                    periph_reset,
   output logic                    io_hold,
   output logic                    io_tristate,
   output logic [5:0]              sys_div,
   output logic                    ram_valid_flag,
   output logic [1:0]              mode,
   output logic                    irq
);

   // register map, all words 32 bits, unused bits read zero:
   //   control  no effect, kept so software has a harmless target
   //   status   mode in the low two bits, ram valid, fast divider
   //   events   sticky: standby entry, stop entry, wake, cancel exit
   //   enable   one bit per event, drives the level interrupt
   //   clear    write one to clear an event bit

   // pin controls for one mode, kept together for the output flops
   typedef struct packed {
      logic cpu_clk_en;
      logic osc_en;
      logic periph_clk_en;
      logic periph_rst;
      logic io_hold;
      logic io_tri;
   } pin_ctrl_t;

   // the whole block state lives in one record: the machine, the strap
   // copy, the bus answer and every pin control, so that each output
   // port comes straight from a flop and no decode can glitch a pin
   // while the machine changes mode
   typedef struct packed {
      op_mode_t               mode;
      logic                   ram_valid;
      logic [5:0]             div;
      logic                   need_strap;
      logic                   instr_nop;
      logic                   fetch_zero;
      logic [`EV_WIDTH-1:0]   ev_status;
      logic [`EV_WIDTH-1:0]   ev_enable;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
      logic                   irq;
      // registered clock, reset and pad controls
      pin_ctrl_t              pins;
   } state_t;

   state_t st;
   state_t next_st;

   // request pending: flag set and mask clear on any source
   function automatic logic pending(input logic [NUM_SRC-1:0] f,
                                    input logic [NUM_SRC-1:0] m);
      return |(f & ~m);
   endfunction : pending

   // status words are read freely; a write to them is refused
   function automatic logic read_only(input logic [11:0] a);
      return (a == `OFS_STATUS) || (a == `OFS_INT_STATUS);
   endfunction : read_only

   // locations that answer without an error
   function automatic logic mapped(input logic [11:0] a);
      return (a == `OFS_MODE_CTRL) || (a == `OFS_STATUS)
          || (a == `OFS_INT_STATUS) || (a == `OFS_INT_ENABLE)
          || (a == `OFS_INT_CLEAR);
   endfunction : mapped

   // status word: mode, ram valid flag and the strap-selected divider
   function automatic logic [31:0] status_word(input op_mode_t   m,
                                               input logic       rv,
                                               input logic [5:0] dv);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`POS_MODE +: 2] = m;
      w[`BIT_RAM_VALID] = rv;
      w[`BIT_DIV_SEL] = (dv == `DIV_FAST);
      return w;
   endfunction : status_word

   // pin controls that a mode asks for; the unused code parks the part
   // with its peripherals held and its pads released
   function automatic pin_ctrl_t pins_for(input op_mode_t m);
      pin_ctrl_t p;
      p = '0;
      unique case (m)
         MODE_ACTIVE: begin
            p.cpu_clk_en = 1'b1;
            p.osc_en = 1'b1;
            p.periph_clk_en = 1'b1;
         end
         MODE_STANDBY: begin
            p.osc_en = 1'b1;
            p.periph_clk_en = 1'b1;
            p.io_hold = 1'b1;
         end
         // stop holds peripherals in reset, outputs high impedance
         MODE_STOP: begin
            p.periph_rst = 1'b1;
            p.io_tri = 1'b1;
         end
         default: begin
            p.periph_rst = 1'b1;
            p.io_tri = 1'b1;
         end
      endcase
      return p;
   endfunction : pins_for

   // decode results shared by the machine and the bus logic
   logic req_pend;
   logic acc;
   logic setup_acc;
   logic done_acc;
   logic [`EV_WIDTH-1:0] ev_set;

   // mode sequencing, register file and interrupt status
   always_comb begin
      next_st = st;
      ev_set = '0;
      acc = psel && penable;
      // the answer is latched on the first access edge, which gives one
      // wait state; a write lands only on the edge where pready is seen
      // high, so a master that gives up early leaves nothing behind
      setup_acc = acc && !st.pready;
      done_acc = acc && st.pready;
      req_pend = pending(int_req_flag, int_mask_bit);
      // pulses, pready and pslverr fall back every cycle unless set below; prdata holds
      next_st.instr_nop = 1'b0;
      next_st.fetch_zero = 1'b0;
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
      // the strap is read once, on the edge after reset release or stop
      // exit; a later change of the pin waits for the next such event
      // strap sampled after reset release or stop exit
      if (st.need_strap) begin
         next_st.div = div_sel ? `DIV_FAST : `DIV_SLOW;
         next_st.need_strap = 1'b0;
      end
      // sleep instructions are only honoured in active mode; the wake
      // conditions are only looked at in the matching sleep mode, so a
      // cancel level or a request seen elsewhere does nothing
      // three-state machine
      unique case (st.mode)
         MODE_ACTIVE: begin
            if (standby_instr || stop_instr) begin
               // a request that cannot be taken with interrupts off would
               // wake the part at once, so the sleep is dropped instead
               // sleep becomes nop when request waits
               if (!global_int_enable && req_pend) begin
                  next_st.instr_nop = 1'b1;
               end else if (stop_instr) begin
                  next_st.mode = MODE_STOP;
                  ev_set[`BIT_EV_STOP] = 1'b1;
               end else begin
                  next_st.mode = MODE_STANDBY;
                  ev_set[`BIT_EV_STANDBY] = 1'b1;
               end
            end
         end
         MODE_STANDBY: begin
            // the wake ignores the global enable: with it off the cpu
            // just carries on after the sleep and the request waits
            // wake on any request
            if (req_pend) begin
               next_st.mode = MODE_ACTIVE;
               ev_set[`BIT_EV_WAKE] = 1'b1;
            end
         end
         MODE_STOP: begin
            // cancel only honoured in stop
            // no counter is kept here: the outside keeps the cancel low
            // for the settle time and the exit follows its release, so
            // a short pulse restarts the cpu on an unsettled oscillator
            // release waits on the input going high again
            if (stop_cancel_n == 1'b0) begin
               next_st.ram_valid = 1'b1;
            end else if (st.ram_valid) begin
               next_st.mode = MODE_ACTIVE;
               next_st.fetch_zero = 1'b1;
               next_st.need_strap = 1'b1;
               ev_set[`BIT_EV_CANCEL] = 1'b1;
            end
         end
      endcase
      // a stop left by reset clears the flag through the reset branch,
      // so only the cancel path can ever show it set
      // entering stop leaves the ram flag clear until cancel arrives
      if (st.mode == MODE_ACTIVE && next_st.mode == MODE_STOP) begin
         next_st.ram_valid = 1'b0;
      end
      // apb answer: one wait state, data and error latched on the first
      // access edge; pready and the error show for exactly one cycle, the data holds
      // until the next access; the bus works in every mode since only the clocks
      // handed out are ever stopped
      if (setup_acc) begin
         next_st.pready = 1'b1;
         next_st.prdata = 32'h0000_0000;
         // holes answer zero with an error; status words refuse writes
         next_st.pslverr = !mapped(paddr) || (pwrite && read_only(paddr));
         if (!pwrite) begin
            unique case (paddr)
               `OFS_STATUS: begin
                  next_st.prdata = status_word(st.mode, st.ram_valid,
                                               st.div);
               end
               `OFS_INT_STATUS: begin
                  next_st.prdata[`EV_WIDTH-1:0] = st.ev_status;
               end
               `OFS_INT_ENABLE: begin
                  next_st.prdata[`EV_WIDTH-1:0] = st.ev_enable;
               end
               default: begin
                  // control and clear words read back as zero
               end
            endcase
         end
      end

      // apb write effect, taken only on the completing edge; a refused
      // write changes nothing
      if (done_acc && pwrite && mapped(paddr) && !read_only(paddr)) begin
         unique case (paddr)
            `OFS_INT_ENABLE: begin
               next_st.ev_enable = pwdata[`EV_WIDTH-1:0];
            end
            `OFS_INT_CLEAR: begin
               // write one to clear; an event of this cycle still wins
               next_st.ev_status = st.ev_status & ~pwdata[`EV_WIDTH-1:0];
            end
            default: begin
               // the control word is accepted and has no effect: sleep
               // comes only from the instruction stream
            end
         endcase
      end
      // an event and its clear in one cycle keep the bit, so software
      // that clears late never loses a fresh event
      // set wins over a same-cycle clear
      next_st.ev_status = next_st.ev_status | ev_set;
      next_st.irq = |(next_st.ev_status & next_st.ev_enable);

      // pin controls follow the coming mode, so they switch on the same
      // edge as the mode itself and a pin never sees a decode glitch
      next_st.pins = pins_for(next_st.mode);
   end

   // one register for the whole state; the next value is built above
   // asynchronous reset to active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // reset restarts the whole part: active mode, slow divider
         // until the strap is read, ram marked not valid
         st.mode       <= MODE_ACTIVE;
         st.ram_valid  <= 1'b0;
         st.div        <= `DIV_SLOW;
         st.need_strap <= 1'b1;
         st.instr_nop  <= 1'b0;
         st.fetch_zero <= 1'b1;
         st.ev_status  <= '0;
         st.ev_enable  <= '0;
         st.prdata     <= 32'h0000_0000;
         st.pready     <= 1'b0;
         st.pslverr    <= 1'b0;
         st.irq        <= 1'b0;
         st.pins       <= '{cpu_clk_en: 1'b1, osc_en: 1'b1,
                            periph_clk_en: 1'b1, periph_rst: 1'b0,
                            io_hold: 1'b0, io_tri: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state flops, no decode on the way out
   assign cpu_clk_en      = st.pins.cpu_clk_en;
   assign osc_enable      = st.pins.osc_en;
   assign periph_clk_en   = st.pins.periph_clk_en;
   assign periph_reset    = st.pins.periph_rst;
   assign io_tristate     = st.pins.io_tri;
   assign io_hold         = st.pins.io_hold;
   assign instr_nop       = st.instr_nop;
   // restart pulse: one cycle after reset release and after stop exit;
   // the cpu treats both alike
   // cpu restarts from zero, registers not restored
   assign fetch_from_zero = st.fetch_zero;
   // divider as a count: 4 or 32 input clocks per system clock
   assign sys_div         = st.div;
   assign ram_valid_flag  = st.ram_valid;
   assign mode            = st.mode;
   assign irq             = st.irq;
   assign prdata          = st.prdata;
   assign pready          = st.pready;
   assign pslverr         = st.pslverr;

endmodule : low_power_mode_controller

// >>> inc/lpm_defines.svh
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH
// register byte offsets
`define OFS_MODE_CTRL   12'h000
`define OFS_STATUS      12'h004
`define OFS_INT_STATUS  12'h008
`define OFS_INT_ENABLE  12'h00C
`define OFS_INT_CLEAR   12'h010
// mode control fields
`define BIT_REQ_STANDBY 0
`define BIT_REQ_STOP    1
// status fields
`define BIT_RAM_VALID   3
`define BIT_DIV_SEL     4
`define POS_MODE        0
// interrupt status fields
`define BIT_EV_STANDBY  0
`define BIT_EV_STOP     1
`define BIT_EV_WAKE     2
`define BIT_EV_CANCEL   3
`define EV_WIDTH        4
// divider ratios
`define DIV_FAST        6'h04
`define DIV_SLOW        6'h20
// settle time in ns and cycles at 50 ns
`define OSC_SETTLE_NS   1000
`define CLK_PERIOD_NS   50
`define OSC_SETTLE_CYC  ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> inc/lpm_pkg.sv
package lpm_pkg;
   typedef enum logic [1:0] {
      MODE_ACTIVE,
      MODE_STANDBY,
      MODE_STOP
   } op_mode_t;
endpackage : lpm_pkg

// >>> verification/lpm_cpu_model.sv
`timescale 1ns/1ps
module lpm_cpu_model (
   // clock
   input  wire logic pclk,
   // cpu and interrupt controller
   output logic       standby_instr,
   output logic       stop_instr,
   output logic       global_int_enable,
   output logic [5:0] int_req_flag,
   output logic [5:0] int_mask_bit,
   // wake pin
   output logic       stop_cancel_n
);
   initial begin
      standby_instr = 1'b0;
      stop_instr = 1'b0;
      global_int_enable = 1'b0;
      int_req_flag = '0;
      int_mask_bit = '1;
      stop_cancel_n = 1'b1;
   end
   // one-cycle sleep instruction pulse
   task sleep(input logic stp);
      @(posedge pclk);
      stop_instr <= stp;
      standby_instr <= !stp;
      @(posedge pclk);
      stop_instr <= 1'b0;
      standby_instr <= 1'b0;
   endtask : sleep
   task irqs(input logic [5:0] f, input logic [5:0] m);
      @(posedge pclk);
      int_req_flag <= f;
      int_mask_bit <= m;
   endtask : irqs
   // held low for n clock cycles
   task cancel(input int n);
      @(posedge pclk);
      stop_cancel_n <= 1'b0;
      repeat (n) @(posedge pclk);
      stop_cancel_n <= 1'b1;
   endtask : cancel
endmodule : lpm_cpu_model

// >>> verification/lpm_asserts.sv
`timescale 1ns/1ps
module lpm_asserts
   import lpm_pkg::*;
#(
   parameter int NUM_SRC = 6
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               standby_instr,
   input wire logic               stop_instr,
   input wire logic               global_int_enable,
   input wire logic [NUM_SRC-1:0] int_req_flag,
   input wire logic [NUM_SRC-1:0] int_mask_bit,
   input wire logic               stop_cancel_n,
   input wire logic               div_sel,
   input wire logic               instr_nop,
   input wire logic               cpu_clk_en,
   input wire logic               fetch_from_zero,
   input wire logic               osc_enable,
   input wire logic               periph_clk_en,
   input wire logic               periph_reset,
   input wire logic               io_hold,
   input wire logic               io_tristate,
   input wire logic [5:0]         sys_div,
   input wire logic               ram_valid_flag,
   input wire logic [1:0]         mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic act;
   logic pend;
   assign act = mode == MODE_ACTIVE;
   assign pend = |(int_req_flag & ~int_mask_bit);
   stby_entry_a: assert property (act && standby_instr && !stop_instr
      && (global_int_enable || !pend) |=> mode == MODE_STANDBY)
      else $error("standby not entered");
   stop_entry_a: assert property (act && stop_instr && !standby_instr
      && (global_int_enable || !pend) |=> mode == MODE_STOP)
      else $error("stop not entered");
   sleep_nop_a: assert property (act && (standby_instr || stop_instr)
      && !global_int_enable && pend |=> instr_nop && act)
      else $error("pending request did not cancel sleep");
   stop_pins_a: assert property (mode == MODE_STOP |-> !osc_enable
      && !cpu_clk_en && periph_reset && io_tristate)
      else $error("stop outputs wrong");
   stby_pins_a: assert property (mode == MODE_STANDBY |-> osc_enable
      && periph_clk_en && !cpu_clk_en && io_hold && !io_tristate)
      else $error("standby outputs wrong");
   stby_wake_a: assert property (mode == MODE_STANDBY && pend |=> act)
      else $error("no wake on request");
   cancel_ign_a: assert property (act && !stop_cancel_n
      && !standby_instr && !stop_instr |=> act)
      else $error("cancel acted outside stop");
   ram_set_a: assert property (mode == MODE_STOP && !stop_cancel_n
      |=> ram_valid_flag) else $error("ram valid not set");
   stop_exit_a: assert property (mode == MODE_STOP && $rose(stop_cancel_n)
      |=> act ##[0:1] fetch_from_zero) else $error("no restart at zero");
   div_pick_a: assert property ($past(mode) == MODE_STOP && act
      |-> ##[1:2] sys_div == (div_sel ? 6'h04 : 6'h20))
      else $error("divider not from strap");
   cover property (act && standby_instr);
   cover property (instr_nop);
   cover property (mode == MODE_STOP && !stop_cancel_n);
endmodule : lpm_asserts
bind low_power_mode_controller lpm_asserts #(.NUM_SRC(NUM_SRC)) i_lpm_asserts (.*);

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`include "lpm_defines.svh"
module tb_top;
   import lpm_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic div_sel, pready, pslverr, rerr, standby_instr, stop_instr;
   logic global_int_enable, instr_nop, cpu_clk_en, fetch_from_zero;
   logic stop_cancel_n, osc_enable, periph_clk_en, periph_reset;
   logic io_hold, io_tristate, ram_valid_flag, irq;
   logic [5:0] int_req_flag, int_mask_bit, sys_div;
   logic [1:0] mode;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdata;
   int err_total = 0, samples_checked = 0;
   always #25 pclk = ~pclk;
   low_power_mode_controller #(.NUM_SRC(6)) i_low_power_mode_controller (.*);
   lpm_cpu_model i_lpm_cpu_model (.*);
   task end_sim;
      if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task chk(input logic [63:0] s, input logic [63:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   // settle a few edges, then sample off the edge
   task cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : cyc
   // apb transfer, waits for pready under a bound
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         err_total++;
         end_sim;
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   initial begin
      div_sel <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      chk({ram_valid_flag, sys_div, mode}, {1'b0, `DIV_SLOW, MODE_ACTIVE});
      apb(1'b1, `OFS_INT_ENABLE, 32'h0000_0001);
      apb(1'b0, `OFS_INT_ENABLE, 32'h0000_0000);
      chk(rdata, 32'h0000_0001);
      i_lpm_cpu_model.sleep(1'b0);
      cyc(0);
      chk({osc_enable, cpu_clk_en, io_hold, mode}, {3'b101, MODE_STANDBY});
      chk(irq, 1'b1);
      apb(1'b1, `OFS_INT_CLEAR, 32'h0000_0001);
      cyc(1);
      chk(irq, 1'b0);
      i_lpm_cpu_model.irqs(6'h04, 6'h3b);
      cyc(2);
      chk(mode, MODE_ACTIVE);
      i_lpm_cpu_model.sleep(1'b1);
      cyc(0);
      chk({instr_nop, mode}, {1'b1, MODE_ACTIVE});
      i_lpm_cpu_model.irqs(6'h00, 6'h3f);
      i_lpm_cpu_model.cancel(3);
      cyc(1);
      chk({ram_valid_flag, mode}, {1'b0, MODE_ACTIVE});
      @(posedge pclk);
      div_sel <= 1'b1;
      i_lpm_cpu_model.sleep(1'b1);
      cyc(0);
      chk({osc_enable, periph_reset, io_tristate, irq, mode}, 6'b011010);
      apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
      chk(rdata, 32'h0000_0006);
      i_lpm_cpu_model.cancel(`OSC_SETTLE_CYC);
      cyc(3);
      chk({ram_valid_flag, sys_div, mode}, {1'b1, `DIV_FAST, MODE_ACTIVE});
      apb(1'b0, `OFS_STATUS, 32'h0000_0000);
      chk(rdata, 32'h0000_0018);
      i_lpm_cpu_model.sleep(1'b1);
      cyc(2);
      @(posedge pclk);
      presetn <= 1'b0;
      cyc(0);
      chk({ram_valid_flag, mode}, {1'b0, MODE_ACTIVE});
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      chk(sys_div, `DIV_FAST);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk({rerr, rdata}, {1'b1, 32'h0000_0000});
      end_sim;
   end
endmodule : tb_top
